// ===== design/sar_pkg.sv
package sar_pkg;
    localparam logic [3:0]  CH_PIN_LAST   = 4'h8;
    localparam logic [3:0]  CH_GROUND     = 4'h9;
    localparam logic [3:0]  CH_VREF       = 4'ha;
    localparam logic [3:0]  CH_TEMP       = 4'hb;
    localparam logic [2:0]  REF_INTERNAL  = 3'h0;
    localparam logic [2:0]  REF_SUPPLY    = 3'h1;
    localparam logic [2:0]  WIN_NONE      = 3'h0;
    localparam logic [2:0]  WIN_BELOW     = 3'h1;
    localparam logic [2:0]  WIN_ABOVE     = 3'h2;
    localparam logic [2:0]  WIN_INSIDE    = 3'h3;
    localparam logic [2:0]  WIN_OUTSIDE   = 3'h4;
    localparam logic [2:0]  ACC_LOG_MAX   = 3'h6;
    localparam logic [4:0]  PRE_TICKS     = 5'h02;
    localparam logic [4:0]  TOP_BIT       = 5'h09;
    localparam logic [4:0]  LAST_BIT_10   = 5'h00;
    localparam logic [4:0]  LAST_BIT_8    = 5'h02;
    localparam logic [3:0]  TICKS_TO_END  = 4'hc;
    localparam logic [9:0]  TRIAL_FIRST   = 10'h200;
    localparam logic [3:0]  LFSR_SEED     = 4'h9;
    localparam logic [8:0]  DIV_BASE      = 9'h002;

    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_SYNC   = 6'b000010,
        S_DELAY  = 6'b000100,
        S_PRE    = 6'b001000,
        S_SAR    = 6'b010000,
        S_FINISH = 6'b100000
    } state_t;
endpackage

// ===== design/sar_clock_divider.sv
module sar_clock_divider (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       hold,
    input  wire logic [2:0] divSelect,
    output logic            tick
);
    logic [8:0] count_reg;
    logic [8:0] count_next;
    logic [8:0] limit;

    // Counter held at zero outside conversions
    always_comb begin
        limit = (sar_pkg::DIV_BASE << divSelect) - 9'h001;
        tick = run && !hold && (count_reg == limit);
        if (!run || tick) begin
            count_next = 9'h000;
        end else if (hold) begin
            count_next = count_reg;
        end else begin
            count_next = count_reg + 9'h001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= 9'h000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// ===== design/sar_converter_control.sv
module sar_converter_control (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic        resolutionSelect,
    input  wire logic        freeRunningBit,
    input  wire logic [2:0]  accumulationCount,
    input  wire logic [3:0]  sampleDelay,
    input  wire logic        sampleDelayVary,
    input  wire logic [2:0]  referenceSelect,
    input  wire logic [2:0]  clockDividerSelect,
    input  wire logic [3:0]  inputChannelSelect,
    input  wire logic        eventStartEnable,
    input  wire logic        startEvent,
    input  wire logic        startWrite,
    input  wire logic        readResult,
    input  wire logic        clearReadyWrite,
    input  wire logic        clearWindowWrite,
    input  wire logic        readyIntEnable,
    input  wire logic        windowIntEnable,
    input  wire logic [2:0]  windowMode,
    input  wire logic [15:0] windowLow,
    input  wire logic [15:0] windowHigh,
    input  wire logic        debugHalt,
    input  wire logic        runWhileDebugHalted,
    input  wire logic        touchControllerEnable,
    input  wire logic        touchStart,
    input  wire logic [3:0]  touchChannel,
    input  wire logic [2:0]  touchReference,
    input  wire logic        compIn,
    output logic             conversionStartBit,
    output logic [15:0]      conversionResult,
    output logic             resultReadyFlag,
    output logic             windowFlag,
    output logic             readyIrq,
    output logic             windowIrq,
    output logic             analogPowerOn,
    output logic [3:0]       channelSelectOut,
    output logic [2:0]       referenceSelectOut,
    output logic             sampleHold,
    output logic [9:0]       sarCode
);
    typedef struct packed {
        sar_pkg::state_t state;
        logic [4:0]      cnt;
        logic [3:0]      tickCnt;
        logic [9:0]      code;
        logic [15:0]     acc;
        logic [6:0]      sampCnt;
        logic            res8;
        logic            startBit;
        logic            ready;
        logic            winFlag;
        logic [15:0]     result;
        logic [3:0]      chan;
        logic [2:0]      reference_select;
        logic            evPrev;
        logic [3:0]      lfsr;
        logic            hold;
    } regs_t;

    regs_t       r_reg;
    regs_t       r_next;
    logic        tick;
    logic        stall;
    logic        runDiv;
    logic        eventEdge;
    logic        startReq;
    logic        doneEvt;
    logic [6:0]  target;
    logic [9:0]  bitMask;
    logic [15:0] sample;
    logic [15:0] accSum;
    logic        winHit;
    logic [3:0]  chanSel;
    logic [2:0]  refPick;
    logic [4:0]  dly;
    logic [4:0]  lastBit;

    sar_clock_divider divider (
        .clock     (clock),
        .rst       (rst),
        .run       (runDiv),
        .hold      (stall),
        .divSelect (clockDividerSelect),
        .tick      (tick)
    );

    always_comb begin
        stall = debugHalt && !runWhileDebugHalted;
        runDiv = enable && (r_reg.state != sar_pkg::S_IDLE);
        chanSel = touchControllerEnable ? touchChannel : inputChannelSelect;
        refPick = touchControllerEnable ? touchReference : referenceSelect;
        eventEdge = startEvent && !r_reg.evPrev;
        if (touchControllerEnable) begin
            startReq = touchStart;
        end else begin
            startReq = startWrite || (eventStartEnable && eventEdge);
        end
        if (accumulationCount > sar_pkg::ACC_LOG_MAX) begin
            target = 7'h01 << sar_pkg::ACC_LOG_MAX;
        end else begin
            target = 7'h01 << accumulationCount;
        end
        bitMask = 10'h001 << r_reg.cnt[3:0];
        lastBit = r_reg.res8 ? sar_pkg::LAST_BIT_8 : sar_pkg::LAST_BIT_10;
        sample = r_reg.res8 ? {8'h00, r_reg.code[9:2]} : {6'h00, r_reg.code};
        accSum = r_reg.acc + sample;
        dly = {1'b0, sampleDelay} + (sampleDelayVary ? {3'h0, r_reg.lfsr[1:0]} : 5'h00);
        doneEvt = enable && !stall && tick && (r_reg.state == sar_pkg::S_FINISH)
                  && ((r_reg.sampCnt + 7'h01) == target);
        case (windowMode)
            sar_pkg::WIN_BELOW:   winHit = accSum < windowLow;
            sar_pkg::WIN_ABOVE:   winHit = accSum > windowHigh;
            sar_pkg::WIN_INSIDE:  winHit = (accSum >= windowLow) && (accSum <= windowHigh);
            sar_pkg::WIN_OUTSIDE: winHit = (accSum < windowLow) || (accSum > windowHigh);
            default:              winHit = 1'b0;
        endcase

        r_next = r_reg;
        r_next.hold = 1'b0;
        r_next.evPrev = startEvent;
        r_next.lfsr = {r_reg.lfsr[2:0], r_reg.lfsr[3] ^ r_reg.lfsr[2]};
        // Clears first so a same-cycle set wins
        if (readResult || clearReadyWrite) begin
            r_next.ready = 1'b0;
        end
        if (clearWindowWrite) begin
            r_next.winFlag = 1'b0;
        end
        if (!enable) begin
            r_next.state = sar_pkg::S_IDLE;
            r_next.startBit = 1'b0;
            r_next.cnt = 5'h00;
            r_next.code = 10'h000;
        end else if (!stall) begin
            if ((r_reg.state == sar_pkg::S_IDLE) || (r_reg.state == sar_pkg::S_FINISH)) begin
                r_next.chan = chanSel;
                r_next.reference_select = refPick;
            end
            case (r_reg.state)
                sar_pkg::S_IDLE: begin
                    if (startReq) begin
                        r_next.startBit = 1'b1;
                        r_next.state = sar_pkg::S_SYNC;
                        r_next.acc = 16'h0000;
                        r_next.sampCnt = 7'h00;
                        r_next.res8 = resolutionSelect;
                    end
                end
                sar_pkg::S_SYNC: begin
                    if (tick) begin
                        r_next.state = sar_pkg::S_PRE;
                        r_next.cnt = 5'h00;
                        r_next.tickCnt = 4'h0;
                    end
                end
                sar_pkg::S_DELAY: begin
                    if (tick) begin
                        if (r_reg.cnt == 5'h00) begin
                            r_next.state = sar_pkg::S_PRE;
                            r_next.tickCnt = 4'h0;
                        end else begin
                            r_next.cnt = r_reg.cnt - 5'h01;
                        end
                    end
                end
                sar_pkg::S_PRE: begin
                    if (tick) begin
                        r_next.tickCnt = r_reg.tickCnt + 4'h1;
                        if (r_reg.cnt == sar_pkg::PRE_TICKS - 5'h01) begin
                            r_next.hold = 1'b1;
                            r_next.state = sar_pkg::S_SAR;
                            r_next.cnt = sar_pkg::TOP_BIT;
                            r_next.code = sar_pkg::TRIAL_FIRST;
                        end else begin
                            r_next.cnt = r_reg.cnt + 5'h01;
                        end
                    end
                end
                sar_pkg::S_SAR: begin
                    if (tick) begin
                        r_next.tickCnt = r_reg.tickCnt + 4'h1;
                        r_next.code = compIn ? r_reg.code : (r_reg.code & ~bitMask);
                        if (r_reg.cnt == lastBit) begin
                            r_next.state = sar_pkg::S_FINISH;
                        end else begin
                            r_next.code = (compIn ? r_reg.code : (r_reg.code & ~bitMask)) | (bitMask >> 1);
                            r_next.cnt = r_reg.cnt - 5'h01;
                        end
                    end
                end
                sar_pkg::S_FINISH: begin
                    if (tick) begin
                        r_next.acc = accSum;
                        if (doneEvt) begin
                            r_next.result = accSum;
                            r_next.ready = 1'b1;
                            if (winHit) begin
                                r_next.winFlag = 1'b1;
                            end
                            if (freeRunningBit && r_reg.startBit) begin
                                r_next.state = sar_pkg::S_PRE;
                                r_next.acc = 16'h0000;
                                r_next.sampCnt = 7'h00;
                                r_next.cnt = 5'h00;
                                r_next.tickCnt = 4'h0;
                                r_next.res8 = resolutionSelect;
                            end else begin
                                r_next.state = sar_pkg::S_IDLE;
                                r_next.startBit = 1'b0;
                            end
                        end else begin
                            r_next.sampCnt = r_reg.sampCnt + 7'h01;
                            r_next.tickCnt = 4'h0;
                            if (dly == 5'h00) begin
                                r_next.state = sar_pkg::S_PRE;
                                r_next.cnt = 5'h00;
                            end else begin
                                r_next.state = sar_pkg::S_DELAY;
                                r_next.cnt = dly - 5'h01;
                            end
                        end
                    end
                end
                default: begin
                    r_next.state = sar_pkg::S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_reg <= '{state: sar_pkg::S_IDLE, cnt: 5'h00, tickCnt: 4'h0, code: 10'h000,
                       acc: 16'h0000, sampCnt: 7'h00, res8: 1'b0, startBit: 1'b0,
                       ready: 1'b0, winFlag: 1'b0, result: 16'h0000, chan: 4'h0,
                       reference_select: sar_pkg::REF_INTERNAL, evPrev: 1'b0,
                       lfsr: sar_pkg::LFSR_SEED, hold: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign conversionStartBit = r_reg.startBit;
    assign conversionResult = r_reg.result;
    assign resultReadyFlag = r_reg.ready;
    assign windowFlag = r_reg.winFlag;
    assign readyIrq = r_reg.ready && readyIntEnable;
    assign windowIrq = r_reg.winFlag && windowIntEnable;
    assign analogPowerOn = enable;
    assign channelSelectOut = r_reg.chan;
    assign referenceSelectOut = r_reg.reference_select;
    assign sampleHold = r_reg.hold;
    assign sarCode = r_reg.code;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_done;
        doneEvt;
    endsequence

    sequence s_sw_start;
        enable && !stall && startWrite && !touchControllerEnable && (r_reg.state == sar_pkg::S_IDLE);
    endsequence

    a_idle_when_off: assert property (!enable |=> (r_reg.state == sar_pkg::S_IDLE) && !r_reg.startBit)
        else $error("converter active while disabled");
    a_ref_locked: assert property (!enable && !$past(enable) |-> $stable(referenceSelectOut))
        else $error("reference changed while disabled");
    a_sw_start: assert property (s_sw_start |=> conversionStartBit)
        else $error("software start not taken");
    a_event_gate: assert property (enable && eventEdge && !eventStartEnable && !startWrite
                                   && !touchControllerEnable && !r_reg.startBit |=> !r_reg.startBit)
        else $error("event start taken while disabled");
    a_result_narrow: assert property (s_done ##0 (accumulationCount == 3'h0) |=> conversionResult[15:10] == 6'h00)
        else $error("single result exceeds ten bits");
    a_ready_set: assert property (s_done |=> resultReadyFlag)
        else $error("ready flag not set at completion");
    a_ready_clear: assert property (resultReadyFlag && readResult && !doneEvt |=> !resultReadyFlag)
        else $error("ready flag not cleared by read");
    a_single_stop: assert property (s_done ##0 !freeRunningBit |=> !conversionStartBit)
        else $error("start bit stays set after single conversion");
    a_free_restart: assert property (s_done ##0 freeRunningBit |=> r_reg.state == sar_pkg::S_PRE)
        else $error("free running did not restart");
    a_cycle_count: assert property (enable && !stall && tick && !r_reg.res8 && (r_reg.state == sar_pkg::S_FINISH)
                                    |-> r_reg.tickCnt == sar_pkg::TICKS_TO_END)
        else $error("conversion length not thirteen cycles");
    a_debug_freeze: assert property (enable && stall |=> r_reg.state == $past(r_reg.state))
        else $error("state moved during debug halt");
    a_window_off: assert property (s_done ##0 (windowMode == sar_pkg::WIN_NONE) && !windowFlag |=> !windowFlag)
        else $error("window flag set with compare off");
endmodule

// ===== tb/sar_analog_model.sv
module sar_analog_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       analogPowerOn,
    input  wire logic       sampleHold,
    input  wire logic [3:0] channelSelectOut,
    input  wire logic [9:0] sarCode,
    input  wire logic [9:0] pinLevel,
    output logic            compIn
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] VREF_LEVEL = 10'h1a0;
    localparam logic [9:0] TEMP_LEVEL = 10'h133;
    logic [9:0] held;
    logic       valid;
    logic       noise;

    // Hold capacitor; the comparator output is meaningless before a sample
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            held  <= 10'h000;
            valid <= 1'b0;
            noise <= 1'b0;
        end else begin
            noise <= ~noise;
            if (!analogPowerOn) begin
                valid <= 1'b0;
            end else if (sampleHold) begin
                valid <= 1'b1;
                case (channelSelectOut)
                    sar_pkg::CH_GROUND: held <= 10'h000;
                    sar_pkg::CH_VREF:   held <= VREF_LEVEL;
                    sar_pkg::CH_TEMP:   held <= TEMP_LEVEL;
                    default:            held <= pinLevel;
                endcase
            end
        end
    end

    assign compIn = valid ? (held >= sarCode) : noise;
endmodule

// ===== tb/sar_converter_control_test.sv
module sar_converter_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, enable, resolutionSelect, freeRunningBit, sampleDelayVary, eventStartEnable;
    logic        startEvent, startWrite, readResult, clearReadyWrite, clearWindowWrite, readyIntEnable;
    logic        windowIntEnable, debugHalt, runWhileDebugHalted, touchControllerEnable, touchStart, compIn;
    logic [2:0]  accumulationCount, referenceSelect, clockDividerSelect, windowMode, touchReference;
    logic [3:0]  sampleDelay, inputChannelSelect, touchChannel;
    logic [15:0] windowLow, windowHigh, conversionResult;
    logic        conversionStartBit, resultReadyFlag, windowFlag, readyIrq, windowIrq, analogPowerOn, sampleHold;
    logic [3:0]  channelSelectOut;
    logic [2:0]  referenceSelectOut;
    logic [9:0]  sarCode, pinLevel;
    int          errTotal, nCompared, holdCount, cyc;

    sar_converter_control DUT (.clock, .rst, .enable, .resolutionSelect, .freeRunningBit, .accumulationCount,
        .sampleDelay, .sampleDelayVary, .referenceSelect, .clockDividerSelect, .inputChannelSelect,
        .eventStartEnable, .startEvent, .startWrite, .readResult, .clearReadyWrite, .clearWindowWrite,
        .readyIntEnable, .windowIntEnable, .windowMode, .windowLow, .windowHigh, .debugHalt,
        .runWhileDebugHalted, .touchControllerEnable, .touchStart, .touchChannel, .touchReference, .compIn,
        .conversionStartBit, .conversionResult, .resultReadyFlag, .windowFlag, .readyIrq, .windowIrq,
        .analogPowerOn, .channelSelectOut, .referenceSelectOut, .sampleHold, .sarCode);
    sar_analog_model ANALOG (.clock, .rst, .analogPowerOn, .sampleHold, .channelSelectOut, .sarCode,
        .pinLevel, .compIn);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) if (sampleHold === 1'b1) holdCount++;

    task automatic finalReport();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chkBit(input logic got, input logic exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chkRange(input int got, input int lo, input int hi, input string what);
        nCompared++;
        if (got < lo || got > hi) begin
            errTotal++;
            $display("BAD %0t %s took %0d cycles", $time, what, got);
        end
    endtask
    // Codes: 0 start, 1 read, 2 clear ready, 3 clear window, else touch start
    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: startWrite <= 1'b1;
            1: readResult <= 1'b1;
            2: clearReadyWrite <= 1'b1;
            3: clearWindowWrite <= 1'b1;
            default: touchStart <= 1'b1;
        endcase
        @(posedge clock);
        {startWrite, readResult, clearReadyWrite, clearWindowWrite, touchStart} <= 5'h00;
    endtask
    task automatic waitReady(output int n);
        n = 0;
        while (resultReadyFlag !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 6000) begin
                errTotal++;
                $display("BAD %0t ready flag never rose", $time);
                finalReport();
            end
        end
    endtask
    task automatic convert(input logic [9:0] lvl, output int n);
        pulse(2);
        pulse(3);
        @(posedge clock);
        pinLevel <= lvl;
        pulse(0);
        @(posedge clock);
        #1;
        chkBit(conversionStartBit, 1'b1, "start bit busy");
        waitReady(n);
        n = n + 1;
    endtask

    task automatic testLatch();
        @(posedge clock);
        inputChannelSelect <= 4'h7;
        referenceSelect <= sar_pkg::REF_SUPPLY;
        pulse(0);
        repeat (3) @(posedge clock);
        #1;
        chkWord({12'h000, channelSelectOut}, 16'h0000, "channel while off");
        chkBit(conversionStartBit, 1'b0, "start while off");
        chkBit(analogPowerOn, 1'b0, "power while off");
        @(posedge clock);
        enable <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chkWord({12'h000, channelSelectOut}, 16'h0007, "channel on");
        chkWord({13'h0000, referenceSelectOut}, {13'h0000, sar_pkg::REF_SUPPLY}, "ref on");
    endtask
    task automatic testSingle(input logic [2:0] sel, input int clearBy);
        int d;
        d = 2 << sel;
        @(posedge clock);
        clockDividerSelect <= sel;
        convert(10'h2a5, cyc);
        chkWord({6'h00, sarCode}, 16'h02a5, "final code");
        chkRange(cyc, 13 * d, 14 * d + 4, "single conversion");
        chkWord(conversionResult, 16'h02a5, "ten-bit result");
        chkBit(readyIrq, 1'b1, "ready irq");
        @(posedge clock);
        #1;
        chkBit(conversionStartBit, 1'b0, "start bit self clear");
        pulse(clearBy);
        #1;
        chkBit(resultReadyFlag, 1'b0, "ready cleared");
        chkBit(readyIrq, 1'b0, "irq cleared");
    endtask
    task automatic testEightBit();
        @(posedge clock);
        resolutionSelect <= 1'b1;
        convert(10'h2a5, cyc);
        chkWord(conversionResult, 16'h00a9, "eight-bit result");
        @(posedge clock);
        resolutionSelect <= 1'b0;
        inputChannelSelect <= sar_pkg::CH_GROUND;
        convert(10'h3ff, cyc);
        chkWord(conversionResult, 16'h0000, "ground channel");
        @(posedge clock);
        inputChannelSelect <= 4'h7;
    endtask
    task automatic testAccum(input logic [2:0] cnt, input logic [9:0] lvl, input logic [15:0] sum);
        @(posedge clock);
        accumulationCount <= cnt;
        holdCount = 0;
        convert(lvl, cyc);
        chkWord(conversionResult, sum, "accumulated sum");
        chkWord(holdCount[15:0], 16'h0001 << cnt, "samples in burst");
        chkRange(cyc, (13 + sampleDelay) * 2 * ((1 << cnt) - 1), 40 * (1 << cnt), "burst");
    endtask
    task automatic testEvent();
        pulse(2);
        startEvent <= 1'b1;
        repeat (60) @(posedge clock);
        #1;
        chkBit(conversionStartBit | resultReadyFlag, 1'b0, "event disabled");
        @(posedge clock);
        startEvent <= 1'b0;
        eventStartEnable <= 1'b1;
        pinLevel <= 10'h155;
        @(posedge clock);
        startEvent <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chkBit(conversionStartBit, 1'b1, "event start");
        pulse(0);
        waitReady(cyc);
        chkWord(conversionResult, 16'h0155, "event result");
        pulse(2);
        repeat (80) @(posedge clock);
        #1;
        chkBit(resultReadyFlag, 1'b0, "busy trigger ignored");
        @(posedge clock);
        startEvent <= 1'b0;
        eventStartEnable <= 1'b0;
    endtask
    task automatic testFree();
        @(posedge clock);
        freeRunningBit <= 1'b1;
        convert(10'h0f0, cyc);
        pulse(2);
        waitReady(cyc);
        chkBit(conversionStartBit, 1'b1, "free running continues");
        chkWord(conversionResult, 16'h00f0, "free result");
        @(posedge clock);
        enable <= 1'b0;
        freeRunningBit <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chkBit(conversionStartBit | analogPowerOn, 1'b0, "disable stops");
        @(posedge clock);
        enable <= 1'b1;
    endtask
    task automatic testWindow(input logic [9:0] lvl, input logic [3:0] want);
        for (int m = 1; m <= 4; m++) begin
            @(posedge clock);
            windowMode <= m[2:0];
            convert(lvl, cyc);
            chkBit(windowFlag, want[m - 1], "window flag");
            chkBit(windowIrq, want[m - 1], "window irq");
        end
    endtask
    task automatic testDebug();
        pulse(2);
        pulse(0);
        debugHalt <= 1'b1;
        repeat (200) @(posedge clock);
        #1;
        chkBit(resultReadyFlag, 1'b0, "halted");
        @(posedge clock);
        debugHalt <= 1'b0;
        waitReady(cyc);
        @(posedge clock);
        runWhileDebugHalted <= 1'b1;
        debugHalt <= 1'b1;
        convert(10'h011, cyc);
        chkRange(cyc, 26, 32, "run while halted");
        @(posedge clock);
        debugHalt <= 1'b0;
    endtask
    task automatic testTouch();
        @(posedge clock);
        touchControllerEnable <= 1'b1;
        touchChannel <= sar_pkg::CH_TEMP;
        pulse(2);
        pulse(0);
        repeat (60) @(posedge clock);
        #1;
        chkBit(resultReadyFlag, 1'b0, "software start refused");
        pulse(4);
        waitReady(cyc);
        chkWord(conversionResult, {6'h00, ANALOG.TEMP_LEVEL}, "touch result");
        @(posedge clock);
        touchControllerEnable <= 1'b0;
    endtask

    initial begin
        {enable, resolutionSelect, freeRunningBit, sampleDelayVary, eventStartEnable, startEvent} = 6'h00;
        {startWrite, readResult, clearReadyWrite, clearWindowWrite, debugHalt, runWhileDebugHalted} = 6'h00;
        {touchControllerEnable, touchStart, touchReference, touchChannel} = 9'h000;
        {accumulationCount, referenceSelect, clockDividerSelect, inputChannelSelect} = 13'h0000;
        {readyIntEnable, windowIntEnable, windowMode, sampleDelay} = 9'h180;
        windowLow = 16'h0100;
        windowHigh = 16'h0300;
        pinLevel = 10'h155;
        {errTotal, nCompared, holdCount} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        chkWord({12'h000, conversionStartBit, resultReadyFlag, windowFlag, analogPowerOn}, 16'h0000, "reset");
        chkWord({13'h0000, referenceSelectOut}, {13'h0000, sar_pkg::REF_INTERNAL}, "reset ref");
        testLatch();
        testSingle(3'h0, 1);
        testSingle(3'h1, 2);
        @(posedge clock);
        clockDividerSelect <= 3'h0;
        testEightBit();
        testWindow(10'h050, 4'b1001);
        testWindow(10'h200, 4'b0100);
        testEvent();
        testFree();
        testDebug();
        testTouch();
        @(posedge clock);
        sampleDelay <= 4'h3;
        sampleDelayVary <= 1'b1;
        testAccum(3'h2, 10'h155, 16'h0554);
        testAccum(3'h6, 10'h3ff, 16'hffc0);
        finalReport();
    end
endmodule
